// ==== src/rcp_pkg.sv ====
// rcp_pkg: register map, field positions and reset values of the
// reset-cause and power-control block.
// assumes a 32-bit axi4-lite slave with word-aligned registers.
package rcp_pkg;
  localparam int          RCP_AW          = 12;
  // power_control offset is printed as a byte address
  localparam logic [11:0] RCP_OFS_PWR     = 12'hf80;
  localparam logic [11:0] RCP_OFS_CAUSE   = 12'hf84;
  localparam logic [11:0] RCP_OFS_IRQ_ST  = 12'hf88;
  localparam logic [11:0] RCP_OFS_IRQ_MSK = 12'hf8c;
  // cause flag positions
  localparam int          RCP_BIT_POR     = 7;
  localparam int          RCP_BIT_HALT    = 6;
  localparam int          RCP_BIT_WDOG    = 5;
  localparam int          RCP_BIT_PIN     = 4;
  localparam logic [7:0]  RCP_CAUSE_RST   = 8'h80;
  // power control fields
  localparam int          RCP_BIT_BO_DIS  = 4;
  localparam int          RCP_BIT_ADC_DIS = 2;
  localparam int          RCP_BIT_CMP_DIS = 1;
  localparam logic [7:0]  RCP_PWR_RST     = 8'h80;
  // event status bits: one per reset or recovery cause
  localparam int          RCP_NEV         = 6;
  localparam int          RCP_EV_PIN      = 0;
  localparam int          RCP_EV_WDOG     = 1;
  localparam int          RCP_EV_DBGR     = 2;
  localparam int          RCP_EV_DPIN     = 3;
  localparam int          RCP_EV_GWAKE    = 4;
  localparam int          RCP_EV_WWAKE    = 5;
  localparam logic [1:0]  RCP_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RCP_RESP_SLVERR = 2'b10;
endpackage

// ==== src/rcp_cause_rec.sv ====
// rcp_cause_rec: the reset cause flags and their update on each event.
// assumes event inputs are one-cycle pulses synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module rcp_cause_rec
  import rcp_pkg::*;
(
  // clock and power-on reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // reset and recovery events
  input  wire logic       ev_pin_reset,
  input  wire logic       ev_wdog_rst,
  input  wire logic       ev_debug_rst,
  input  wire logic       ev_debug_pin,
  input  wire logic       ev_gpio_wake,
  input  wire logic       ev_wdog_wake,
  // software read clears the external-pin flag
  input  wire logic       rd_clear,
  // flags
  output logic      [7:0] cause
);
  logic [3:0] flags_reg;
  logic [3:0] flags_next;

  // flags_next order: por, halt, wdog, pin
  always_comb begin
    flags_next = flags_reg;
    if (rd_clear) begin
      flags_next[0] = 1'b0;
    end
    if (ev_debug_rst || ev_debug_pin) begin
      flags_next = 4'b1000;
    end else if (ev_wdog_wake) begin
      flags_next = 4'b0110;
    end else if (ev_gpio_wake) begin
      flags_next = 4'b0100;
    end else if (ev_wdog_rst) begin
      flags_next = 4'b0010;
    end else if (ev_pin_reset) begin
      flags_next = 4'b0001;
    end
  end

  // only the power-on reset initialises the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= RCP_CAUSE_RST[7:4];
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign cause = {flags_reg, 4'h0};
endmodule
`default_nettype wire

// ==== src/rcp_top.sv ====
// rcp_top: reset-cause status and analog power control, axi4-lite slave.
// assumes aresetn is the power-on reset; other resets arrive as event
// pulses and do not reset this block.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - pin reset sets pin flag; read clears
// - power-on or gpio wake clears pin flag
// - pin reset reads por0 halt0 wdog0 pin1
// - watchdog reset reads only wdog set
// - debugger reset reads only por set
// - debug pin wake reads only por set
// - gpio wake reads only halt set
// - watchdog wake sets halt and wdog
// - status reset only by power-on
// - status low nibble reads zero
// - brown-out on when bit4 clear and option set
// - bit2 set disables converter
// - bit1 set disables comparator
module rcp_top
  import rcp_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address and data
  input  wire logic [RCP_AW-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [RCP_AW-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // reset and recovery events, one-cycle pulses
  input  wire logic                  ev_pin_reset,
  input  wire logic                  ev_wdog_rst,
  input  wire logic                  ev_debug_rst,
  input  wire logic                  ev_debug_pin,
  input  wire logic                  ev_gpio_wake,
  input  wire logic                  ev_wdog_wake,
  // nonvolatile option
  input  wire logic                  brownout_always_on_option,
  // analog enables
  output logic                       brownout_enable,
  output logic                       adc_enable,
  output logic                       comparator_enable,
  // interrupt
  output logic                       irq
);
  logic [7:0]          cause;
  logic [7:0]          pwr_reg,   pwr_next;
  logic [RCP_NEV-1:0]  ist_reg,   ist_next;
  logic [RCP_NEV-1:0]  imsk_reg,  imsk_next;
  logic                aw_hold_reg, aw_hold_next;
  logic                w_hold_reg,  w_hold_next;
  logic [RCP_AW-1:0]   awaddr_reg,  awaddr_next;
  logic [31:0]         wdata_reg,   wdata_next;
  logic [3:0]          wstrb_reg,   wstrb_next;
  logic                bvalid_reg,  bvalid_next;
  logic [1:0]          bresp_reg,   bresp_next;
  logic                rvalid_reg,  rvalid_next;
  logic [31:0]         rdata_reg,   rdata_next;
  logic [1:0]          rresp_reg,   rresp_next;
  logic                wr_go;
  logic                rd_go;
  logic                rd_clear;
  logic [RCP_NEV-1:0]  ev_vec;

  assign ev_vec = {ev_wdog_wake, ev_gpio_wake, ev_debug_pin,
                   ev_debug_rst, ev_wdog_rst, ev_pin_reset};

  rcp_cause_rec u_cause (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ev_pin_reset (ev_pin_reset),
    .ev_wdog_rst  (ev_wdog_rst),
    .ev_debug_rst (ev_debug_rst),
    .ev_debug_pin (ev_debug_pin),
    .ev_gpio_wake (ev_gpio_wake),
    .ev_wdog_wake (ev_wdog_wake),
    .rd_clear     (rd_clear),
    .cause        (cause)
  );

  // channels held until both address and data are in
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_clear = rd_go && (s_axi_araddr == RCP_OFS_CAUSE);

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    pwr_next     = pwr_reg;
    imsk_next    = imsk_reg;
    ist_next     = ist_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RCP_RESP_OKAY;
      unique case (awaddr_reg)
        RCP_OFS_PWR: begin
          if (wstrb_reg[0]) begin
            pwr_next = wdata_reg[7:0];
          end
        end
        RCP_OFS_CAUSE: begin
        end
        RCP_OFS_IRQ_ST: begin
          if (wstrb_reg[0]) begin
            ist_next = ist_reg & ~wdata_reg[RCP_NEV-1:0];
          end
        end
        RCP_OFS_IRQ_MSK: begin
          if (wstrb_reg[0]) begin
            imsk_next = wdata_reg[RCP_NEV-1:0];
          end
        end
        default: bresp_next = RCP_RESP_SLVERR;
      endcase
    end
    // event set wins over a same-cycle clear
    ist_next = ist_next | ev_vec;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rd_go) begin
      rvalid_next = 1'b1;
      rresp_next  = RCP_RESP_OKAY;
      rdata_next  = 32'h0;
      unique case (s_axi_araddr)
        RCP_OFS_PWR:     rdata_next[7:0] = pwr_reg;
        RCP_OFS_CAUSE:   rdata_next[7:0] = cause;
        RCP_OFS_IRQ_ST:  rdata_next[RCP_NEV-1:0] = ist_reg;
        RCP_OFS_IRQ_MSK: rdata_next[RCP_NEV-1:0] = imsk_reg;
        default:         rresp_next = RCP_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RCP_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RCP_RESP_OKAY;
      pwr_reg     <= RCP_PWR_RST;
      ist_reg     <= '0;
      imsk_reg    <= '0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      pwr_reg     <= pwr_next;
      ist_reg     <= ist_next;
      imsk_reg    <= imsk_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
  assign irq          = |(ist_reg & imsk_reg);

  assign brownout_enable   = !pwr_reg[RCP_BIT_BO_DIS]
                             && brownout_always_on_option;
  assign adc_enable        = !pwr_reg[RCP_BIT_ADC_DIS];
  assign comparator_enable = !pwr_reg[RCP_BIT_CMP_DIS];

  // assertions
  property p_pin_set;
    @(posedge aclk) disable iff (!aresetn)
    ev_pin_reset && !(ev_debug_rst || ev_debug_pin || ev_wdog_wake || ev_gpio_wake
      || ev_wdog_rst) |=> cause[7:4] == 4'b0001;
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin reset flags wrong");

  property p_rd_clr;
    @(posedge aclk) disable iff (!aresetn)
    rd_clear && !(|ev_vec) |=> !cause[RCP_BIT_PIN];
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("pin flag not cleared on read");

  property p_gwake;
    @(posedge aclk) disable iff (!aresetn)
    ev_gpio_wake && !(ev_debug_rst || ev_debug_pin || ev_wdog_wake)
      |=> cause[7:4] == 4'b0100;
  endproperty
  a_gwake: assert property (p_gwake) else $error("gpio wake flags wrong");

  property p_wwake;
    @(posedge aclk) disable iff (!aresetn)
    ev_wdog_wake && !(ev_debug_rst || ev_debug_pin) |=> cause[7:4] == 4'b0110;
  endproperty
  a_wwake: assert property (p_wwake) else $error("watchdog wake flags wrong");

  property p_wrst;
    @(posedge aclk) disable iff (!aresetn)
    ev_wdog_rst && !(ev_debug_rst || ev_debug_pin || ev_wdog_wake || ev_gpio_wake)
      |=> cause[7:4] == 4'b0010;
  endproperty
  a_wrst: assert property (p_wrst) else $error("watchdog reset flags wrong");

  property p_dbg;
    @(posedge aclk) disable iff (!aresetn)
    ev_debug_rst || ev_debug_pin |=> cause[7:4] == 4'b1000;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug reset flags wrong");

  property p_stable;
    @(posedge aclk) disable iff (!aresetn)
    !(|ev_vec) && !rd_clear |=> $stable(cause);
  endproperty
  a_stable: assert property (p_stable) else $error("flags changed with no event");

  property p_low;
    @(posedge aclk) disable iff (!aresetn)
    rvalid_reg && $past(rd_clear) |-> s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_low: assert property (p_low) else $error("reserved bits nonzero");

  property p_bo;
    @(posedge aclk) disable iff (!aresetn)
    wr_go && awaddr_reg == RCP_OFS_PWR && wstrb_reg[0]
      |=> brownout_enable == (!$past(wdata_reg[RCP_BIT_BO_DIS])
      && brownout_always_on_option);
  endproperty
  a_bo: assert property (p_bo) else $error("brown-out enable wrong");

  property p_adc;
    @(posedge aclk) disable iff (!aresetn)
    wr_go && awaddr_reg == RCP_OFS_PWR && wstrb_reg[0]
      |=> adc_enable == !$past(wdata_reg[RCP_BIT_ADC_DIS])
      && comparator_enable == !$past(wdata_reg[RCP_BIT_CMP_DIS]);
  endproperty
  a_adc: assert property (p_adc) else $error("analog enable not following write");

  c_rd_cause: cover property (@(posedge aclk) rd_clear ##1 rvalid_reg);
  c_wr_pwr: cover property (@(posedge aclk) wr_go && awaddr_reg == RCP_OFS_PWR);
  c_irq: cover property (@(posedge aclk) $rose(irq));
endmodule
`default_nettype wire

// ==== testbench/test_reset_cause_and_power_control.sv ====
// test_reset_cause_and_power_control: self-checking bench for rcp_top.
// assumes rcp_pkg map and one-cycle event pulses; bench is the bus master.
`timescale 1ns/1ns
`default_nettype none
module test_reset_cause_and_power_control;
  import rcp_pkg::*;
  logic aclk, aresetn, opt, irq, bo_en, adc_en, cmp_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [5:0]  evs;
  int          num_errors, total_checks, i;
  logic [7:0]  cause_tbl [6] = '{8'h10, 8'h20, 8'h80, 8'h80, 8'h40, 8'h60};
  logic [7:0]  pwr_tbl [5] = '{8'h80, 8'h90, 8'h84, 8'h82, 8'h96};

  rcp_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .ev_pin_reset(evs[RCP_EV_PIN]), .ev_wdog_rst(evs[RCP_EV_WDOG]),
    .ev_debug_rst(evs[RCP_EV_DBGR]), .ev_debug_pin(evs[RCP_EV_DPIN]),
    .ev_gpio_wake(evs[RCP_EV_GWAKE]), .ev_wdog_wake(evs[RCP_EV_WWAKE]),
    .brownout_always_on_option(opt), .brownout_enable(bo_en),
    .adc_enable(adc_en), .comparator_enable(cmp_en), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_val({31'h0, got}, {31'h0, exp}, m);
  endtask

  task automatic timeout(input string m);
    num_errors++;
    $display("[FAIL] %0t timeout %s", $time, m);
    test_done();
  endtask

  // write one byte, hold each channel until taken, then take the response
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int   n;
    // one edge between calls so bready is never lowered and raised at once
    @(posedge aclk);
    tb = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) chk_val({30'h0, bresp}, {30'h0, er}, "bresp");
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) timeout("write");
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic ta, tr;
    int   n;
    @(posedge aclk);
    tr = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr) chk_val(rdata, {24'h0, ed}, "rdata");
      if (tr) chk_val({30'h0, rresp}, {30'h0, er}, "rresp");
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) timeout("read");
  endtask

  task automatic pulse(input int k);
    evs[k] <= 1'b1;
    @(posedge aclk);
    evs <= 6'h00;
    repeat (2) @(posedge aclk);
  endtask

  // analog enables follow power_control bits and the option
  task automatic chk_pwr(input logic [7:0] v);
    axi_wr(RCP_OFS_PWR, v, RCP_RESP_OKAY);
    axi_rd(RCP_OFS_PWR, v, RCP_RESP_OKAY);
    chk_bit(bo_en, ~v[RCP_BIT_BO_DIS] & opt, "brownout");
    chk_bit(adc_en, ~v[RCP_BIT_ADC_DIS], "adc");
    chk_bit(cmp_en, ~v[RCP_BIT_CMP_DIS], "comparator");
  endtask

  initial begin
    num_errors = 0;
    total_checks = 0;
    aresetn = 1'b0;
    opt = 1'b0;
    evs = 6'h00;
    awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_bit(bo_en, 1'b0, "bo reset");
    axi_rd(RCP_OFS_PWR, RCP_PWR_RST, RCP_RESP_OKAY);
    axi_wr(RCP_OFS_CAUSE, 8'hf0, RCP_RESP_OKAY);
    axi_rd(RCP_OFS_CAUSE, RCP_CAUSE_RST, RCP_RESP_OKAY);
    axi_rd(12'h000, 8'h00, RCP_RESP_SLVERR);
    axi_wr(12'h000, 8'h55, RCP_RESP_SLVERR);
    for (i = 0; i < 5; i++) chk_pwr(pwr_tbl[i]);
    opt <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 5; i++) chk_pwr(pwr_tbl[i]);
    pulse(RCP_EV_PIN);
    axi_rd(RCP_OFS_CAUSE, 8'h10, RCP_RESP_OKAY);
    axi_rd(RCP_OFS_CAUSE, 8'h00, RCP_RESP_OKAY);
    pulse(RCP_EV_PIN);
    pulse(RCP_EV_GWAKE);
    axi_rd(RCP_OFS_CAUSE, 8'h40, RCP_RESP_OKAY);
    axi_wr(RCP_OFS_IRQ_ST, 8'h3f, RCP_RESP_OKAY);
    axi_wr(RCP_OFS_IRQ_MSK, 8'h3f, RCP_RESP_OKAY);
    chk_bit(irq, 1'b0, "irq idle");
    // each cause in turn: flags, sticky status, interrupt and its clear
    for (i = 0; i < 6; i++) begin
      pulse(i);
      chk_bit(irq, 1'b1, "irq set");
      axi_rd(RCP_OFS_CAUSE, cause_tbl[i], RCP_RESP_OKAY);
      axi_rd(RCP_OFS_IRQ_ST, 8'h01 << i, RCP_RESP_OKAY);
      axi_wr(RCP_OFS_IRQ_ST, 8'h01 << i, RCP_RESP_OKAY);
      chk_bit(irq, 1'b0, "irq clear");
    end
    axi_wr(RCP_OFS_IRQ_MSK, 8'h00, RCP_RESP_OKAY);
    pulse(RCP_EV_WDOG);
    chk_bit(irq, 1'b0, "irq masked");
    axi_rd(RCP_OFS_IRQ_ST, 8'h02, RCP_RESP_OKAY);
    axi_rd(RCP_OFS_PWR, 8'h96, RCP_RESP_OKAY);
    pulse(RCP_EV_PIN);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(RCP_OFS_CAUSE, RCP_CAUSE_RST, RCP_RESP_OKAY);
    axi_rd(RCP_OFS_PWR, RCP_PWR_RST, RCP_RESP_OKAY);
    chk_bit(adc_en, 1'b1, "adc reset");
    test_done();
  end
endmodule
`default_nettype wire
